/* test/tb_ulin_uart.sv */
`timescale 1ns/1ps
module tb_ulin_uart import ulin_pkg::*; ;
   logic clk = 0, rst_b = 0, bit_tick = 0, tick_en = 1, cfg_wr = 0, tx_wr = 0, rx_rd = 0;
   logic [1:0] tc = 0;
   logic [7:0] tx_wdata = '0, addr_range_q;
   logic [IRQ_N-1:0] irq_clear = '0, irq_raw_q, irq_masked_q;
   ulin_ctrl_t cfg_data = '0, c;
   ulin_rx_entry_t rx_rdata_q;
   ulin_flags_t flags_q;
   logic serial_in, serial_out_q, irq_q, rds, rdb, tds, tdb;
   logic [31:0] snap, tmr, t1;
   int errors = 0, checks_done = 0;
   always #4 clk = ~clk;
   // bit period of four clocks keeps frames short
   always @(posedge clk) begin
      tc <= tc + 2'h1;
      bit_tick <= tick_en && tc == 2'h3;
   end
   ulin_uart u_dut (.clk(clk), .rst_b(rst_b), .bit_tick(bit_tick), .serial_in(serial_in),
      .serial_out_q(serial_out_q), .cfg_wr(cfg_wr), .cfg_data(cfg_data), .tx_wr(tx_wr),
      .tx_wdata(tx_wdata), .rx_rd(rx_rd), .rx_rdata_q(rx_rdata_q), .irq_clear(irq_clear),
      .flags_q(flags_q), .irq_raw_q(irq_raw_q), .irq_masked_q(irq_masked_q), .irq_q(irq_q),
      .addr_range_q(addr_range_q), .sync_snapshot_q(snap), .sync_timer_q(tmr),
      .rx_dma_single_q(rds), .rx_dma_burst_q(rdb), .tx_dma_single_q(tds),
      .tx_dma_burst_q(tdb));
   ulin_node u_node (.clk(clk), .bit_tick(bit_tick), .line_q(serial_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic rst(input ulin_ctrl_t v);
      @(posedge clk) rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      cfg_wr <= 1'b1;
      cfg_data <= v;
      @(posedge clk) cfg_wr <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge clk) tx_wr <= 1'b1;
      tx_wdata <= d;
      @(posedge clk) tx_wr <= 1'b0;
   endtask
   task automatic rd();
      @(posedge clk) rx_rd <= 1'b1;
      @(posedge clk) rx_rd <= 1'b0;
      @(negedge clk);
   endtask
   task automatic wait_raw(input int b);
      for (int i = 0; i < 3000 && irq_raw_q[b] !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic wait_rx();
      for (int i = 0; i < 3000 && flags_q.rx_queue_empty !== 1'b0; i++) @(negedge clk);
      repeat (2) @(negedge clk);
   endtask
   // transmitter frozen by stopping the bit strobe
   task automatic t_queue();
      tick_en <= 1'b0;
      rst('0);
      chk(flags_q, 5'h14);
      wr(8'h11);
      wr(8'h22);
      repeat (2) @(negedge clk);
      chk(flags_q, 5'h0C);
      rst('{queue_en: 1'b1, tx_dma_enable: 1'b1, default: '0});
      chk({tds, tdb}, 2'h3);
      repeat (16) wr(8'h5A);
      repeat (2) @(negedge clk);
      chk({flags_q.tx_queue_full, tds, tdb}, 3'h4);
      tick_en <= 1'b1;
   endtask
   task automatic t_loop();
      rst('{loopback: 1'b1, queue_en: 1'b1, rx_dma_enable: 1'b1, irq_mask: 10'h010,
         default: '0});
      wr(8'hA5);
      wait_rx();
      chk({rds, rdb, irq_raw_q[IRQ_TMO]}, 3'h4);
      wait_raw(IRQ_TMO);
      chk(irq_q, 1'b1);
      rd();
      chk(rx_rdata_q, 12'h0A5);
      repeat (3) @(negedge clk);
      chk(irq_raw_q[IRQ_TMO], 1'b0);
   endtask
   // looped address frame: ninth bit from sticky odd, end-of-transmit event
   task automatic t_addr_tx();
      rst('{loopback: 1'b1, queue_en: 1'b1, ninth_bit_mode_enable: 1'b1, sticky_odd: 1'b1,
         end_of_tx_mode: 1'b1, station_addr: 8'h12, station_mask: 8'hFF, default: '0});
      @(posedge clk) irq_clear <= '1;
      @(posedge clk) irq_clear <= '0;
      wr(8'h12);
      wait_raw(IRQ_ADDR);
      chk({irq_raw_q[IRQ_TX], irq_raw_q[IRQ_ADDR], flags_q.rx_queue_empty}, 3'h7);
   endtask
   task automatic t_nine();
      c = '{queue_en: 1'b1, ninth_bit_mode_enable: 1'b1, station_addr: 8'h12,
         station_mask: 8'hFF, irq_mask: 10'h200, default: '0};
      rst(c);
      u_node.send_char(8'h13, 1'b1, 1'b1);
      u_node.send_char(8'h77, 1'b1, 1'b0);
      repeat (4) @(negedge clk);
      chk({flags_q.rx_queue_empty, irq_raw_q[IRQ_ADDR]}, 2'h2);
      u_node.send_char(8'h12, 1'b1, 1'b1);
      u_node.send_char(8'h3D, 1'b1, 1'b0);
      wait_rx();
      chk({irq_q, irq_raw_q[IRQ_ADDR]}, 2'h3);
      rd();
      chk(rx_rdata_q, 12'h03D);
      @(posedge clk) irq_clear <= 10'h200;
      @(posedge clk) irq_clear <= '0;
      repeat (2) @(negedge clk);
      chk({irq_q, irq_raw_q[IRQ_ADDR]}, 2'h0);
      c.station_mask = 8'hF0;
      rst(c);
      chk(addr_range_q, 8'h10);
      u_node.send_char(8'h1C, 1'b1, 1'b1);
      repeat (4) @(negedge clk);
      chk(irq_raw_q[IRQ_ADDR], 1'b1);
   endtask
   task automatic t_sync();
      rst('{lin_en: 1'b1, rx_dma_enable: 1'b1, dma_stop_on_error: 1'b1, default: '0});
      t1 = tmr;
      @(negedge clk);
      chk(tmr - t1, 32'h1);
      u_node.send_break(12);
      chk(irq_raw_q[IRQ_SYNC1], 1'b0);
      chk(rds, 1'b0);
      fork
         u_node.send_break(13);
         begin
            wait_raw(IRQ_SYNC1);
            t1 = snap;
            chk({irq_raw_q[IRQ_SYNC1], irq_raw_q[IRQ_SYNC5]}, 2'h2);
            wait_raw(IRQ_SYNC5);
         end
      join
      chk(snap - t1, 32'h20);
   endtask
   task automatic t_master();
      int n;
      n = 0;
      rst('{lin_en: 1'b1, lin_master: 1'b1, break_length_field: 2'h2, queue_en: 1'b1,
         default: '0});
      wr(8'h55);
      for (int i = 0; i < 400 && serial_out_q !== 1'b0; i++) @(negedge clk);
      while (serial_out_q === 1'b0 && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk(n, 60);
   endtask
   task automatic results();
      if (errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      t_queue();
      t_loop();
      t_addr_tx();
      t_nine();
      t_sync();
      t_master();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      results();
   end
endmodule

/* test/ulin_node.sv */
`timescale 1ns/1ps
module ulin_node (
   // clock and bit strobe
   input wire logic clk,
   input wire logic bit_tick,
   // line toward the device, pulled up while idle
   output logic line_q
);
   initial begin
      line_q = 1'b1;
   end
   task automatic hold(input logic v, input int n);
      for (int i = 0; i < n; i++) begin
         line_q <= v;
         @(posedge clk iff bit_tick);
      end
   endtask
   // two stop bits leave the receiver time to push before the next start
   task automatic send_char(input logic [7:0] d, input logic nine, input logic b9);
      // every line change lands on a bit strobe edge, so each bit is a full period
      @(posedge clk iff bit_tick);
      hold(1'b0, 1);
      for (int i = 0; i < 8; i++) hold(d[i], 1);
      if (nine) hold(b9, 1);
      hold(1'b1, 2);
   endtask
   task automatic send_break(input int n);
      @(posedge clk iff bit_tick);
      hold(1'b0, n);
      hold(1'b1, 1);
      send_char(8'h55, 1'b0, 1'b0);
   endtask
endmodule

/* verilog/ulin_fifo.sv */
`timescale 1ns/1ps
module ulin_fifo import ulin_pkg::*; #(
   parameter int W = 8,
   parameter int DEPTH = QDEPTH,
   localparam int AW = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // depth select: low keeps one entry only
   input wire logic deep,
   // fill side
   input wire logic push,
   input wire logic [W-1:0] din,
   // drain side
   input wire logic pop,
   output logic [W-1:0] dout,
   // status
   output logic [AW:0] count,
   output logic empty,
   output logic full
);
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d, lim;
   logic push_ok, pop_ok;

   assign lim = deep ? (AW+1)'(DEPTH) : (AW+1)'(1);
   assign empty = (cnt_q == '0);
   assign full = (cnt_q >= lim);
   assign count = cnt_q;
   assign dout = mem_q[rd_q];

   always_comb begin
      push_ok = push && !full;
      pop_ok = pop && !empty;
      wr_d = push_ok ? wr_q + 1'b1 : wr_q;
      rd_d = pop_ok ? rd_q + 1'b1 : rd_q;
      cnt_d = cnt_q + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push_ok) begin
         mem_q[wr_q] <= din;
      end
   end
endmodule

/* verilog/ulin_pkg.sv */
package ulin_pkg;
   localparam int QDEPTH = 16;
   localparam int CW = $clog2(QDEPTH) + 1;
   localparam int RXW = 12;
   localparam int BRK_MIN_BITS = 13;
   localparam int RX_IDLE_BITS = 32;
   localparam logic [7:0] SYNC_BYTE = 8'h55;
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [2:0] TRIG_RST = 3'h2;
   localparam int IRQ_N = 10;
   localparam int IRQ_OVR = 0;
   localparam int IRQ_BRK = 1;
   localparam int IRQ_PAR = 2;
   localparam int IRQ_FRM = 3;
   localparam int IRQ_TMO = 4;
   localparam int IRQ_RX = 5;
   localparam int IRQ_TX = 6;
   localparam int IRQ_SYNC1 = 7;
   localparam int IRQ_SYNC5 = 8;
   localparam int IRQ_ADDR = 9;
   localparam logic [IRQ_N-1:0] IRQ_ERR = 10'h00F;

   typedef struct packed {
      logic loopback;
      logic queue_en;
      logic lin_en;
      logic lin_master;
      logic [1:0] break_length_field;
      logic ninth_bit_mode_enable;
      logic par_en;
      logic sticky_odd;
      logic end_of_tx_mode;
      logic [2:0] tx_trigger_select;
      logic [2:0] rx_trigger_select;
      logic rx_dma_enable;
      logic tx_dma_enable;
      logic dma_stop_on_error;
      logic [7:0] station_addr;
      logic [7:0] station_mask;
      logic [IRQ_N-1:0] irq_mask;
   } ulin_ctrl_t;

   localparam ulin_ctrl_t CTRL_RST = '{tx_trigger_select: TRIG_RST,
      rx_trigger_select: TRIG_RST, station_mask: MASK_RST, default: '0};

   typedef struct packed {
      logic ovr;
      logic brk;
      logic par;
      logic frm;
      logic [7:0] data;
   } ulin_rx_entry_t;

   typedef struct packed {
      logic tx_queue_empty;
      logic tx_queue_full;
      logic rx_queue_empty;
      logic rx_queue_full;
      logic rx_overrun;
   } ulin_flags_t;

   // eighths of depth: 1/8, 1/4, 1/2, 3/4, 7/8
   function automatic logic [CW-1:0] ulin_trig_level(input logic [2:0] sel);
      int k;
      case (sel)
         3'h0: k = 1;
         3'h1: k = 2;
         3'h2: k = 4;
         3'h3: k = 6;
         default: k = 7;
      endcase
      return CW'(QDEPTH * k / 8);
   endfunction
endpackage

/* verilog/ulin_rx.sv */
`timescale 1ns/1ps
module ulin_rx import ulin_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // one strobe per bit period
   input wire logic bit_tick,
   input wire logic rxd,
   // format
   input wire logic nine_en,
   input wire logic par_en,
   // received character, valid for one cycle
   output logic valid_q,
   output logic [7:0] data_q,
   output logic bit9_q,
   output logic par_err_q,
   output logic frm_err_q,
   output logic brk_q
);
   typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_NINTH, RX_STOP} ulin_rx_st_t;
   ulin_rx_st_t st_q, st_d;
   logic [7:0] sh_q, sh_d;
   logic [2:0] cnt_q, cnt_d;
   logic b9_q, b9_d, valid_d, par_d, frm_d, brk_d;

   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      b9_d = b9_q;
      valid_d = 1'b0;
      par_d = par_err_q;
      frm_d = frm_err_q;
      brk_d = brk_q;
      if (bit_tick) begin
         case (st_q)
            RX_IDLE: if (!rxd) begin
               st_d = RX_DATA;
               cnt_d = 3'h0;
               b9_d = 1'b0;
            end
            RX_DATA: begin
               sh_d = {rxd, sh_q[7:1]};
               cnt_d = cnt_q + 3'h1;
               if (cnt_q == 3'h7) begin
                  st_d = (nine_en || par_en) ? RX_NINTH : RX_STOP;
               end
            end
            RX_NINTH: begin
               b9_d = rxd;
               st_d = RX_STOP;
            end
            RX_STOP: begin
               valid_d = 1'b1;
               frm_d = !rxd;
               brk_d = !rxd && (sh_q == 8'h00) && !b9_q;
               par_d = par_en && !nine_en && (^sh_q != b9_q);
               st_d = RX_IDLE;
            end
            default: st_d = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= RX_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 3'h0;
         b9_q <= 1'b0;
         valid_q <= 1'b0;
         par_err_q <= 1'b0;
         frm_err_q <= 1'b0;
         brk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         b9_q <= b9_d;
         valid_q <= valid_d;
         par_err_q <= par_d;
         frm_err_q <= frm_d;
         brk_q <= brk_d;
      end
   end

   assign data_q = sh_q;
   assign bit9_q = b9_q;
endmodule

/* verilog/ulin_uart.sv */
`timescale 1ns/1ps
module ulin_uart import ulin_pkg::*; #(
   parameter int TIMER_W = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // one strobe per bit period from the baud generator
   input wire logic bit_tick,
   // serial line
   input wire logic serial_in,
   output logic serial_out_q,
   // configuration, loaded while cfg_wr is high
   input wire logic cfg_wr,
   input wire ulin_ctrl_t cfg_data,
   // data port
   input wire logic tx_wr,
   input wire logic [7:0] tx_wdata,
   input wire logic rx_rd,
   output ulin_rx_entry_t rx_rdata_q,
   // status and interrupts
   input wire logic [IRQ_N-1:0] irq_clear,
   output ulin_flags_t flags_q,
   output logic [IRQ_N-1:0] irq_raw_q,
   output logic [IRQ_N-1:0] irq_masked_q,
   output logic irq_q,
   output logic [7:0] addr_range_q,
   // sync field timing
   output logic [TIMER_W-1:0] sync_snapshot_q,
   output logic [TIMER_W-1:0] sync_timer_q,
   // dma requests
   output logic rx_dma_single_q,
   output logic rx_dma_burst_q,
   output logic tx_dma_single_q,
   output logic tx_dma_burst_q
);
   typedef enum logic [2:0] {TX_IDLE, TX_BRK, TX_DATA, TX_NINTH, TX_STOP} ulin_tx_st_t;
   typedef enum logic {LIN_HUNT, LIN_EDGES} ulin_lin_st_t;

   logic [1:0] rst_sync_q;
   logic rst_n;
   ulin_ctrl_t ctrl_q, ctrl_d;
   ulin_tx_st_t tx_st_q, tx_st_d;
   ulin_lin_st_t lin_st_q, lin_st_d;
   logic [7:0] sh_q, sh_d;
   logic [4:0] bcnt_q, bcnt_d, brk_bits;
   logic par_q, par_d, brk_due_q, brk_due_d, out_d, tx_pop, eot_ev;
   logic [7:0] tx_head;
   logic [CW-1:0] tx_cnt, rx_cnt, tx_lvl, rx_lvl;
   logic tx_empty, tx_full, rx_empty, rx_full;
   logic rx_line, rx_valid, rx_bit9, rx_par, rx_frm, rx_brk, rx_push;
   logic [7:0] rx_data;
   logic [RXW-1:0] rx_head;
   ulin_rx_entry_t rx_entry, rdata_d;
   logic addr_ok_q, addr_ok_d, ovr_pend_q, ovr_pend_d, addr_hit;
   logic [5:0] tmo_q, tmo_d;
   logic [3:0] low_q, low_d;
   logic [2:0] edge_q, edge_d;
   logic rx_prev_q, fall, slave;
   logic [TIMER_W-1:0] timer_d, snap_d;
   logic rx_lvl_q, tx_lvl_q, rx_lvl_now, tx_lvl_now, dma_blk;
   logic [IRQ_N-1:0] ev, raw_d;

   // release reset through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_comb begin
      ctrl_d = cfg_wr ? cfg_data : ctrl_q;
   end

   assign tx_lvl = ulin_trig_level(ctrl_q.tx_trigger_select);
   assign rx_lvl = ulin_trig_level(ctrl_q.rx_trigger_select);
   assign brk_bits = 5'(BRK_MIN_BITS) + {3'h0, ctrl_q.break_length_field};
   assign rx_line = ctrl_q.loopback ? serial_out_q : serial_in;
   assign slave = ctrl_q.lin_en && !ctrl_q.lin_master;

   // queues stay one deep until queue_enable is set
   ulin_fifo #(.W(8), .DEPTH(QDEPTH)) u_txq (
      .clk(clk), .rst_n(rst_n), .deep(ctrl_q.queue_en),
      .push(tx_wr), .din(tx_wdata), .pop(tx_pop), .dout(tx_head),
      .count(tx_cnt), .empty(tx_empty), .full(tx_full));

   ulin_fifo #(.W(RXW), .DEPTH(QDEPTH)) u_rxq (
      .clk(clk), .rst_n(rst_n), .deep(ctrl_q.queue_en),
      .push(rx_push), .din(rx_entry), .pop(rx_rd), .dout(rx_head),
      .count(rx_cnt), .empty(rx_empty), .full(rx_full));

   ulin_rx u_rx (
      .clk(clk), .rst_n(rst_n), .bit_tick(bit_tick), .rxd(rx_line),
      .nine_en(ctrl_q.ninth_bit_mode_enable), .par_en(ctrl_q.par_en),
      .valid_q(rx_valid), .data_q(rx_data), .bit9_q(rx_bit9),
      .par_err_q(rx_par), .frm_err_q(rx_frm), .brk_q(rx_brk));

   // transmitter; the sync byte and identifier come from the queue like any data
   always_comb begin
      tx_st_d = tx_st_q;
      sh_d = sh_q;
      bcnt_d = bcnt_q;
      out_d = serial_out_q;
      par_d = par_q;
      brk_due_d = brk_due_q;
      tx_pop = 1'b0;
      eot_ev = 1'b0;
      if (tx_st_q == TX_IDLE && tx_empty) begin
         brk_due_d = 1'b1;
      end
      if (bit_tick) begin
         case (tx_st_q)
            TX_IDLE: if (!tx_empty) begin
               out_d = 1'b0;
               bcnt_d = 5'h0;
               if (ctrl_q.lin_en && ctrl_q.lin_master && brk_due_q) begin
                  tx_st_d = TX_BRK;
                  bcnt_d = 5'h1;
               end else begin
                  tx_pop = 1'b1;
                  sh_d = tx_head;
                  par_d = ^tx_head;
                  tx_st_d = TX_DATA;
               end
            end
            TX_BRK: begin
               if (bcnt_q == brk_bits) begin
                  out_d = 1'b1;
                  brk_due_d = 1'b0;
                  tx_st_d = TX_IDLE;
               end else begin
                  bcnt_d = bcnt_q + 5'h1;
               end
            end
            TX_DATA: begin
               out_d = sh_q[0];
               sh_d = {1'b0, sh_q[7:1]};
               bcnt_d = bcnt_q + 5'h1;
               if (bcnt_q == 5'h7) begin
                  tx_st_d = (ctrl_q.ninth_bit_mode_enable || ctrl_q.par_en) ? TX_NINTH : TX_STOP;
               end
            end
            TX_NINTH: begin
               // address bytes only by forcing sticky odd parity
               out_d = ctrl_q.ninth_bit_mode_enable ? ctrl_q.sticky_odd : par_q;
               tx_st_d = TX_STOP;
            end
            TX_STOP: begin
               out_d = 1'b1;
               tx_st_d = TX_IDLE;
               eot_ev = tx_empty;
            end
            default: tx_st_d = TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
         tx_st_q <= TX_IDLE;
         sh_q <= 8'h00;
         bcnt_q <= 5'h0;
         par_q <= 1'b0;
         brk_due_q <= 1'b1;
         serial_out_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         tx_st_q <= tx_st_d;
         sh_q <= sh_d;
         bcnt_q <= bcnt_d;
         par_q <= par_d;
         brk_due_q <= brk_due_d;
         serial_out_q <= out_d;
      end
   end

   // receive side: address filter, overrun, timeout, sync field timing
   assign fall = rx_prev_q && !rx_line;
   assign addr_hit = (rx_data & ctrl_q.station_mask) == addr_range_q;

   always_comb begin
      addr_ok_d = addr_ok_q;
      ovr_pend_d = ovr_pend_q;
      rx_push = 1'b0;
      ev = '0;
      rx_entry = '{ovr_pend_q, rx_brk, rx_par, rx_frm, rx_data};
      if (rx_valid) begin
         ev[IRQ_BRK] = rx_brk;
         ev[IRQ_PAR] = rx_par;
         ev[IRQ_FRM] = rx_frm;
         if (ctrl_q.ninth_bit_mode_enable && rx_bit9) begin
            addr_ok_d = addr_hit;
            ev[IRQ_ADDR] = addr_hit;
         end else if (!ctrl_q.ninth_bit_mode_enable || addr_ok_q) begin
            if (rx_full) begin
               ev[IRQ_OVR] = 1'b1;
               ovr_pend_d = 1'b1;
            end else begin
               rx_push = 1'b1;
               ovr_pend_d = 1'b0;
            end
         end
      end
      tmo_d = tmo_q;
      if (rx_empty || rx_valid) begin
         tmo_d = 6'h0;
      end else if (bit_tick && tmo_q != 6'(RX_IDLE_BITS)) begin
         tmo_d = tmo_q + 6'h1;
         ev[IRQ_TMO] = (tmo_q == 6'(RX_IDLE_BITS - 1));
      end
      rx_lvl_now = (rx_cnt >= rx_lvl);
      tx_lvl_now = (tx_cnt < tx_lvl);
      ev[IRQ_RX] = rx_lvl_now && !rx_lvl_q;
      ev[IRQ_TX] = ctrl_q.end_of_tx_mode ? eot_ev : (tx_lvl_now && !tx_lvl_q);
      // bus slave sync: timer, break hunt, edge capture
      timer_d = slave ? sync_timer_q + 1'b1 : '0;
      snap_d = sync_snapshot_q;
      lin_st_d = lin_st_q;
      edge_d = edge_q;
      low_d = low_q;
      if (bit_tick) begin
         low_d = rx_line ? 4'h0 : (low_q == 4'hF ? low_q : low_q + 4'h1);
      end
      case (lin_st_q)
         LIN_HUNT: if (slave && rx_line && low_q >= 4'(BRK_MIN_BITS)) begin
            lin_st_d = LIN_EDGES;
            edge_d = 3'h0;
         end
         LIN_EDGES: if (!slave) begin
            lin_st_d = LIN_HUNT;
         end else if (fall) begin
            edge_d = edge_q + 3'h1;
            if (edge_q == 3'h0) begin
               snap_d = sync_timer_q;
               ev[IRQ_SYNC1] = 1'b1;
            end else if (edge_q == 3'h4) begin
               snap_d = sync_timer_q;
               ev[IRQ_SYNC5] = 1'b1;
               lin_st_d = LIN_HUNT;
            end
         end
         default: lin_st_d = LIN_HUNT;
      endcase
      // a new event wins over a clear in the same cycle
      raw_d = (irq_raw_q & ~irq_clear) | ev;
      if (rx_empty && !ev[IRQ_TMO]) begin
         raw_d[IRQ_TMO] = 1'b0;
      end
      rdata_d = (rx_rd && !rx_empty) ? ulin_rx_entry_t'(rx_head) : rx_rdata_q;
      dma_blk = ctrl_q.dma_stop_on_error && |(irq_raw_q & IRQ_ERR);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ok_q <= 1'b0;
         ovr_pend_q <= 1'b0;
         tmo_q <= 6'h0;
         lin_st_q <= LIN_HUNT;
         edge_q <= 3'h0;
         low_q <= 4'h0;
         rx_prev_q <= 1'b1;
         rx_lvl_q <= 1'b0;
         tx_lvl_q <= 1'b1; // an empty queue already sits below any level
         sync_timer_q <= '0;
         sync_snapshot_q <= '0;
         irq_raw_q <= '0;
         irq_masked_q <= '0;
         irq_q <= 1'b0;
         rx_rdata_q <= '0;
         flags_q <= '0;
         addr_range_q <= 8'h00;
         rx_dma_single_q <= 1'b0;
         rx_dma_burst_q <= 1'b0;
         tx_dma_single_q <= 1'b0;
         tx_dma_burst_q <= 1'b0;
      end else begin
         addr_ok_q <= addr_ok_d;
         ovr_pend_q <= ovr_pend_d;
         tmo_q <= tmo_d;
         lin_st_q <= lin_st_d;
         edge_q <= edge_d;
         low_q <= low_d;
         rx_prev_q <= rx_line;
         rx_lvl_q <= rx_lvl_now;
         tx_lvl_q <= tx_lvl_now;
         sync_timer_q <= timer_d;
         sync_snapshot_q <= snap_d;
         irq_raw_q <= raw_d;
         irq_masked_q <= raw_d & ctrl_q.irq_mask;
         irq_q <= |(raw_d & ctrl_q.irq_mask);
         rx_rdata_q <= rdata_d;
         flags_q <= '{tx_queue_empty: tx_empty, tx_queue_full: tx_full,
            rx_queue_empty: rx_empty, rx_queue_full: rx_full,
            rx_overrun: irq_raw_q[IRQ_OVR]};
         addr_range_q <= ctrl_q.station_addr & ctrl_q.station_mask;
         rx_dma_single_q <= ctrl_q.rx_dma_enable && !rx_empty && !dma_blk;
         rx_dma_burst_q <= ctrl_q.rx_dma_enable && rx_lvl_now && !dma_blk;
         tx_dma_single_q <= ctrl_q.tx_dma_enable && !tx_full;
         tx_dma_burst_q <= ctrl_q.tx_dma_enable && tx_lvl_now;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_first_edge;
      lin_st_q == LIN_EDGES && slave && fall && edge_q == 3'h0;
   endsequence
   sequence s_fifth_edge;
      lin_st_q == LIN_EDGES && slave && fall && edge_q == 3'h4;
   endsequence

   a_break_length: assert property (tx_st_q == TX_BRK && bit_tick && bcnt_q == brk_bits
      |=> serial_out_q && tx_st_q == TX_IDLE) else $error("break end wrong");
   a_slave_break: assert property (lin_st_q == LIN_EDGES && $past(lin_st_q) == LIN_HUNT
      |-> $past(low_q) >= 4'(BRK_MIN_BITS)) else $error("short break taken");
   a_first_edge: assert property (s_first_edge |=> irq_raw_q[IRQ_SYNC1]
      && sync_snapshot_q == $past(sync_timer_q)) else $error("first edge lost");
   a_fifth_edge: assert property (s_fifth_edge |=> irq_raw_q[IRQ_SYNC5]
      && lin_st_q == LIN_HUNT) else $error("fifth edge lost");
   a_addr_drop: assert property (rx_valid && ctrl_q.ninth_bit_mode_enable && rx_bit9
      |=> rx_cnt <= $past(rx_cnt)) else $error("address byte stored");
   a_timeout_set: assert property (bit_tick && !rx_empty && !rx_valid
      && tmo_q == 6'(RX_IDLE_BITS-1) |=> irq_raw_q[IRQ_TMO]) else $error("no timeout");
   a_clear_raw: assert property (irq_clear[IRQ_PAR] && !ev[IRQ_PAR]
      |=> !irq_raw_q[IRQ_PAR] && !irq_masked_q[IRQ_PAR]) else $error("clear ignored");
   a_dma_stop: assert property (ctrl_q.dma_stop_on_error && |(irq_raw_q & IRQ_ERR)
      |=> !rx_dma_single_q && !rx_dma_burst_q) else $error("dma not stopped");
   a_tx_dma: assert property (ctrl_q.tx_dma_enable && !tx_full
      |=> tx_dma_single_q) else $error("tx single missing");
endmodule
